// ### rtl/pdc_pkg.sv
package pdc_pkg;

   // Counter width and fixed count values
   localparam int PDC_W = 8;
   localparam logic [7:0] PDC_MAX = 8'hFF;
   localparam logic [7:0] PDC_ZERO = 8'h00;
   localparam logic [7:0] PDC_ONE = 8'h01;

   // Counter action chosen by the control pins, strongest first
   typedef enum logic [2:0] {
      PDC_M_CLEAR = 3'b000,
      PDC_M_ALOAD = 3'b001,
      PDC_M_SLOAD = 3'b010,
      PDC_M_COUNT = 3'b011,
      PDC_M_HOLD = 3'b100
   } pdc_mode_e;

   // Controller register byte offsets on APB
   localparam logic [7:0] PDC_OFF_CTRL = 8'h00;
   localparam logic [7:0] PDC_OFF_PRESET = 8'h04;
   localparam logic [7:0] PDC_OFF_STATUS = 8'h08;
   localparam logic [7:0] PDC_OFF_MASK = 8'h0C;
   localparam logic [7:0] PDC_OFF_ZCOUNT = 8'h10;

   // Control register fields
   localparam int PDC_CTRL_RUN = 0;
   localparam int PDC_CTRL_SLOAD = 1;
   localparam int PDC_CTRL_ALOAD = 2;
   localparam int PDC_CTRL_CLEAR = 3;
   localparam int PDC_CTRL_W = 4;
   localparam logic [3:0] PDC_CTRL_RST = 4'h0;

   // Status and mask fields
   localparam int PDC_ST_ZERO = 0;
   localparam int PDC_ST_LOAD = 1;
   localparam int PDC_ST_W = 2;
   localparam logic [1:0] PDC_ST_RST = 2'h0;

   // Zero event counter width and reset
   localparam int PDC_ZC_W = 16;
   localparam logic [15:0] PDC_ZC_RST = 16'h0000;
   localparam logic [15:0] PDC_ZC_ONE = 16'h0001;

endpackage

// ### rtl/pdc_if.sv
`timescale 1ns/1ps
`default_nettype none

// Pin bundle between the counter and the logic driving it
interface pdc_if;
   logic clear_to_max_n;
   logic async_load_n;
   logic sync_load_n;
   logic count_enable_n;
   logic [7:0] preset_value_in;
   logic zero_detect_n;

   // Counter end
   modport dev (
      input clear_to_max_n,
      input async_load_n,
      input sync_load_n,
      input count_enable_n,
      input preset_value_in,
      output zero_detect_n
   );

   // Controlling end
   modport ctl (
      output clear_to_max_n,
      output async_load_n,
      output sync_load_n,
      output count_enable_n,
      output preset_value_in,
      input zero_detect_n
   );
endinterface

`default_nettype wire

// ### rtl/pdc_counter.sv
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module pdc_counter (
   input wire logic CLK,
   input wire logic RST_N,
   pdc_if.dev pins,
   output logic [pdc_pkg::PDC_W-1:0] COUNT,
   output logic [2:0] MODE,
   output logic WRAP
);
   import pdc_pkg::*;

   // Whole state of the counter
   typedef struct packed {
      logic [7:0] count;
      pdc_mode_e mode;
      logic wrap;
   } pdc_dev_s;

   // Reset image: clear leaves the counter at full scale
   localparam pdc_dev_s PDC_DEV_RST = '{
      count: PDC_MAX,
      mode: PDC_M_CLEAR,
      wrap: 1'b0
   };

   pdc_dev_s st;
   pdc_dev_s next_st;
   pdc_mode_e now_mode;
   logic [7:0] live_count;
   logic rst_all_n;
   logic at_zero;

   // Strongest active control wins, all tested low
   function automatic pdc_mode_e pdc_decode(
      input logic clr_n,
      input logic aload_n,
      input logic sload_n,
      input logic cen_n
   );
      pdc_mode_e m;
      m = PDC_M_HOLD;
      if (!clr_n)
      begin
         m = PDC_M_CLEAR;
      end
      else if (!aload_n)
      begin
         m = PDC_M_ALOAD;
      end
      else if (!sload_n)
      begin
         m = PDC_M_SLOAD;
      end
      else if (!cen_n)
      begin
         m = PDC_M_COUNT;
      end
      return m;
   endfunction

   // Action selected by the pins this cycle
   always_comb
   begin
      now_mode = pdc_decode(pins.clear_to_max_n, pins.async_load_n,
                            pins.sync_load_n, pins.count_enable_n);
   end

   // Clear joins the system reset so full scale appears with no edge
   assign rst_all_n = RST_N & pins.clear_to_max_n;

   // Count seen by the zero detector right now.
   // An async load cannot be stored by an asynchronous flip-flop input
   // without taking a port value, so the preset word is muxed in front
   // of the register instead and written into it on the next edge.
   always_comb
   begin
      case (pdc_decode(pins.clear_to_max_n, pins.async_load_n,
                       pins.sync_load_n, pins.count_enable_n))
         PDC_M_CLEAR:
         begin
            live_count = PDC_MAX;
         end
         PDC_M_ALOAD:
         begin
            live_count = pins.preset_value_in;
         end
         default:
         begin
            live_count = st.count;
         end
      endcase
   end

   // Zero detect is combinational so a chained stage sees it in the
   // same cycle; it stays low the whole clock period at zero count while count enable is active
   always_comb
   begin
      at_zero = (live_count == PDC_ZERO);
      pins.zero_detect_n = ~(at_zero & ~pins.count_enable_n);
   end

   // Next state from the chosen action
   always_comb
   begin
      next_st = st;
      next_st.mode = now_mode;
      next_st.wrap = 1'b0;
      case (now_mode)
         PDC_M_CLEAR:
         begin
            next_st.count = PDC_MAX;
         end
         PDC_M_ALOAD:
         begin
            // Keep the forced word so it remains after release
            next_st.count = pins.preset_value_in;
         end
         PDC_M_SLOAD:
         begin
            // Enable is ignored here on purpose
            next_st.count = pins.preset_value_in;
         end
         PDC_M_COUNT:
         begin
            // 8-bit subtract rolls zero over to full scale
            next_st.count = st.count - PDC_ONE;
            next_st.wrap = (st.count == PDC_ZERO);
         end
         PDC_M_HOLD:
         begin
            next_st.count = st.count;
         end
         default:
         begin
            next_st.count = st.count;
         end
      endcase
   end

   // Single state register; clear or reset load full scale
   always_ff @(posedge CLK or negedge rst_all_n)
   begin
      if (!rst_all_n)
      begin
         st <= PDC_DEV_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   // User view comes straight from the flip-flops.
   // Limitation: an async load shows on COUNT from the next edge only,
   // while the zero detector already follows it.
   always_comb
   begin
      COUNT = st.count;
      MODE = st.mode;
      WRAP = st.wrap;
   end

   // Note for chains on one clock: the last stage output can spike
   // between stages; whoever consumes it samples it on the clock.
   // This end relies on that and adds no gating of its own.

endmodule

`default_nettype wire

// ### rtl/pdc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module pdc_ctrl (
   input wire logic CLK,
   input wire logic RST_N,
   pdc_if.ctl pins,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ
);
   import pdc_pkg::*;

   // Whole state of the controller
   typedef struct packed {
      logic [PDC_CTRL_W-1:0] ctrl;
      logic [7:0] preset;
      logic [PDC_ST_W-1:0] status;
      logic [PDC_ST_W-1:0] mask;
      logic [PDC_ZC_W-1:0] zcount;
      logic sload;
      logic ack;
      logic err;
      logic [31:0] rdata;
   } pdc_ctl_s;

   localparam pdc_ctl_s PDC_CTL_RST = '{
      ctrl: PDC_CTRL_RST,
      preset: PDC_ZERO,
      status: PDC_ST_RST,
      mask: PDC_ST_RST,
      zcount: PDC_ZC_RST,
      sload: 1'b0,
      ack: 1'b0,
      err: 1'b0,
      rdata: 32'h0000_0000
   };

   pdc_ctl_s st;
   pdc_ctl_s next_st;
   logic first;
   logic wr;
   logic [PDC_ST_W-1:0] ev;

   // Address decode used for both writes and error flag
   function automatic logic pdc_mapped(input logic [7:0] a);
      return (a == PDC_OFF_CTRL) || (a == PDC_OFF_PRESET) ||
             (a == PDC_OFF_STATUS) || (a == PDC_OFF_MASK) ||
             (a == PDC_OFF_ZCOUNT);
   endfunction

   // Access takes one wait state so read data comes from a flip-flop
   always_comb
   begin
      first = PSEL & PENABLE & ~st.ack;
      wr = PSEL & PENABLE & st.ack & PWRITE & pdc_mapped(PADDR);
      // Zero detect is sampled on the clock, which hides chain spikes
      ev = '0;
      ev[PDC_ST_ZERO] = ~pins.zero_detect_n;
      ev[PDC_ST_LOAD] = st.sload;
   end

   // Next state: bus, events, pin pulse
   always_comb
   begin
      next_st = st;
      next_st.ack = first;
      next_st.sload = 1'b0;
      if (first)
      begin
         next_st.err = ~pdc_mapped(PADDR);
         next_st.rdata = 32'h0000_0000;
         case (PADDR)
            PDC_OFF_CTRL: next_st.rdata[PDC_CTRL_W-1:0] = st.ctrl;
            PDC_OFF_PRESET: next_st.rdata[7:0] = st.preset;
            PDC_OFF_STATUS: next_st.rdata[PDC_ST_W-1:0] = st.status;
            PDC_OFF_MASK: next_st.rdata[PDC_ST_W-1:0] = st.mask;
            PDC_OFF_ZCOUNT: next_st.rdata[PDC_ZC_W-1:0] = st.zcount;
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
      if (wr)
      begin
         case (PADDR)
            PDC_OFF_CTRL:
            begin
               next_st.ctrl = PWDATA[PDC_CTRL_W-1:0];
               next_st.ctrl[PDC_CTRL_SLOAD] = 1'b0;
               next_st.sload = PWDATA[PDC_CTRL_SLOAD];
            end
            PDC_OFF_PRESET: next_st.preset = PWDATA[7:0];
            PDC_OFF_STATUS: next_st.status = st.status & ~PWDATA[PDC_ST_W-1:0];
            PDC_OFF_MASK: next_st.mask = PWDATA[PDC_ST_W-1:0];
            default: next_st.ctrl = st.ctrl;
         endcase
      end
      // Set wins over a write-one clear in the same cycle
      next_st.status = next_st.status | ev;
      if (ev[PDC_ST_ZERO])
      begin
         next_st.zcount = st.zcount + PDC_ZC_ONE;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st <= PDC_CTL_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Pins from flip-flops, every control driven active low
   always_comb
   begin
      pins.clear_to_max_n = ~st.ctrl[PDC_CTRL_CLEAR];
      pins.async_load_n = ~st.ctrl[PDC_CTRL_ALOAD];
      pins.sync_load_n = ~st.sload;
      pins.count_enable_n = ~st.ctrl[PDC_CTRL_RUN];
      pins.preset_value_in = st.preset;
      PRDATA = st.rdata;
      PREADY = st.ack;
      PSLVERR = st.ack & st.err;
      IRQ = |(st.status & st.mask);
   end

endmodule

`default_nettype wire

// ### tb/pdc_properties.sv
`timescale 1ns/1ps
`default_nettype none

// Pin-level checks on the link between controller and counter
module pdc_properties (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic clear_to_max_n,
   input wire logic async_load_n,
   input wire logic sync_load_n,
   input wire logic count_enable_n,
   input wire logic [7:0] preset_value_in,
   input wire logic zero_detect_n,
   input wire logic [pdc_pkg::PDC_W-1:0] COUNT
);
   import pdc_pkg::*;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   // No asynchronous control active, so the live count is the register
   sequence s_calm;
      clear_to_max_n && async_load_n;
   endsequence

   // Every control idle, so the count must stand still
   sequence s_idle;
      clear_to_max_n && async_load_n && sync_load_n && count_enable_n;
   endsequence

   // Sync load with no asynchronous control above it
   sequence s_sload;
      clear_to_max_n && async_load_n && !sync_load_n;
   endsequence

   // Plain counting with nothing stronger pending
   sequence s_run;
      clear_to_max_n && async_load_n && sync_load_n && !count_enable_n;
   endsequence

   chk_count_down: assert property (s_run ##1 s_calm |-> COUNT == $past(COUNT) - PDC_ONE)
      else $error("count did not step down by one");
   chk_hold_count: assert property (s_idle ##1 s_calm |-> $stable(COUNT))
      else $error("count moved while disabled");
   chk_zero_flag: assert property (s_calm |-> zero_detect_n == !(COUNT == PDC_ZERO && !count_enable_n))
      else $error("zero detect wrong");
   chk_sync_load: assert property (s_sload ##1 s_calm
      |-> COUNT == $past(preset_value_in))
      else $error("sync load missed preset");
   // Async load shows at once on zero detect, the register follows at the edge
   chk_async_load: assert property (clear_to_max_n && !async_load_n
      |-> zero_detect_n == !(preset_value_in == PDC_ZERO && !count_enable_n)
      ##1 (!clear_to_max_n || COUNT == $past(preset_value_in)))
      else $error("async load missed preset");
   chk_clear_max: assert property (!clear_to_max_n |-> COUNT == PDC_MAX && zero_detect_n)
      else $error("clear did not force maximum");
   chk_wrap_max: assert property (s_run ##0 COUNT == PDC_ZERO ##1 s_calm
      |-> COUNT == PDC_MAX && zero_detect_n)
      else $error("zero did not wrap to maximum");
   chk_enable_off: assert property (count_enable_n |-> zero_detect_n)
      else $error("zero detect low while disabled");
endmodule

`default_nettype wire

// ### tb/presettable_down_counter8_tb.sv
`timescale 1ns/1ps
`default_nettype none

module presettable_down_counter8_tb;
   import pdc_pkg::*;

   typedef struct packed {logic [7:0] pre; logic [3:0] ctl; logic [7:0] exp;} pdc_row_s;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, wrap, err;
   logic [7:0] paddr, count;
   logic [2:0] mode;
   logic [31:0] pwdata, prdata, q;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   // Preset, control word, count expected while it acts and after release
   pdc_row_s rows [6] = '{'{8'hA5, 4'h2, 8'hA5}, '{8'h01, 4'h4, 8'h01}, '{8'h3C, 4'h8, 8'hFF},
      '{8'h80, 4'hC, 8'hFF}, '{8'h5A, 4'h6, 8'h5A}, '{8'h00, 4'h2, 8'h00}};

   pdc_if pins ();
   pdc_counter u_pdc_counter (.CLK(clk), .RST_N(rst_n), .pins(pins), .COUNT(count), .MODE(mode),
      .WRAP(wrap));
   pdc_ctrl u_pdc_ctrl (.CLK(clk), .RST_N(rst_n), .pins(pins), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ(irq));
   pdc_properties u_pdc_properties (.CLK(clk), .RST_N(rst_n),
      .clear_to_max_n(pins.clear_to_max_n), .async_load_n(pins.async_load_n),
      .sync_load_n(pins.sync_load_n), .count_enable_n(pins.count_enable_n),
      .preset_value_in(pins.preset_value_in), .zero_detect_n(pins.zero_detect_n), .COUNT(count));

   // Free running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Compare of values and of single flags
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s got %0h want %0h", $time, m, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp, input string m);
      chk_val({31'h0, got}, {31'h0, exp}, m);
   endtask

   // One APB transfer; ready and read data are taken at the rising edge that ends it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      settle(0);
      chk_val(count, PDC_MAX, "reset count");
      chk_flag(pins.zero_detect_n, 1'b1, "reset zero detect");
      chk_flag(irq, 1'b0, "reset irq");
      apb(1'b0, PDC_OFF_CTRL, 32'h0);
      chk_val(q, 32'h0, "reset ctrl");
      chk_flag(err, 1'b0, "mapped no error");
      $display("test reset done");
      foreach (rows[i])
      begin
         apb(1'b1, PDC_OFF_PRESET, {24'h0, rows[i].pre});
         apb(1'b1, PDC_OFF_CTRL, {28'h0, rows[i].ctl});
         settle(3);
         chk_val(count, rows[i].exp, "row count");
         apb(1'b1, PDC_OFF_CTRL, 32'h0);
         settle(3);
         chk_val(count, rows[i].exp, "row hold");
         chk_flag(pins.zero_detect_n, 1'b1, "row zero detect");
      end
      $display("test table done");
      apb(1'b1, PDC_OFF_PRESET, 32'h2);
      apb(1'b1, PDC_OFF_CTRL, 32'h2);
      settle(2);
      // Load and run together: the load must win over the enable
      apb(1'b1, PDC_OFF_CTRL, 32'h3);
      @(negedge clk);
      @(negedge clk);
      chk_val(count, 32'h2, "load beats enable");
      chk_val({29'h0, mode}, {29'h0, PDC_M_SLOAD}, "mode sync load");
      @(negedge clk);
      while (pins.zero_detect_n !== 1'b0)
         @(negedge clk);
      chk_val(count, PDC_ZERO, "zero count");
      @(negedge clk);
      chk_val(count, PDC_MAX, "wrap count");
      chk_flag(wrap, 1'b1, "wrap pulse");
      chk_val({29'h0, mode}, {29'h0, PDC_M_COUNT}, "mode count");
      chk_flag(pins.zero_detect_n, 1'b1, "zero one period");
      @(negedge clk);
      chk_val(count, 8'hFE, "after wrap");
      apb(1'b1, PDC_OFF_CTRL, 32'h0);
      settle(2);
      q = {24'h0, count};
      settle(4);
      chk_val(count, q, "stopped count");
      $display("test count done");
      // Exactly one edge saw zero with counting on
      apb(1'b0, PDC_OFF_ZCOUNT, 32'h0);
      chk_val(q, 32'h1, "zero events");
      apb(1'b0, PDC_OFF_STATUS, 32'h0);
      chk_val(q, 32'h3, "status");
      chk_flag(irq, 1'b0, "masked irq");
      apb(1'b1, PDC_OFF_MASK, 32'h1);
      settle(1);
      chk_flag(irq, 1'b1, "irq raised");
      apb(1'b1, PDC_OFF_STATUS, 32'h1);
      settle(1);
      chk_flag(irq, 1'b0, "irq cleared");
      apb(1'b0, PDC_OFF_STATUS, 32'h0);
      chk_val(q, 32'h2, "status left");
      apb(1'b0, 8'h20, 32'h0);
      chk_val(q, 32'h0, "unmapped data");
      chk_flag(err, 1'b1, "unmapped error");
      $display("test irq done");
      @(posedge clk);
      rst_n <= 1'b0;
      settle(1);
      chk_val(count, PDC_MAX, "second reset");
      chk_flag(irq, 1'b0, "second reset irq");
      @(posedge clk);
      rst_n <= 1'b1;
      // First setup cycle right at the first edge after release
      apb(1'b0, PDC_OFF_STATUS, 32'h0);
      chk_val(q, 32'h0, "status after reset");
      chk_val(count, PDC_MAX, "count after reset");
      $display("test second reset done");
      give_verdict();
   end
endmodule

`default_nettype wire
